// ===== hdl/hsc_halt_ctrl.sv
// halt standby controller: standby control register, cpu clock gate, bus idle
// assumes a cpu core with a plain register port and separate interrupt inputs
//
// Functional notes
// - writing one to the halt request bit enters halt mode
// - only the dedicated immediate-move write reaches the register; 01h requests halt
// - halt request with a release already pending does not halt
// - oscillator, system clock, peripherals run; io and ram are untouched
// - cpu stops in halt but macro service transfers still run
// - halt bus: low lines float, middle hold, upper low, strobes high, address_strobe low
// - exactly three release sources: nmi, maskable interrupt, reset
// - a nonmaskable interrupt request releases halt
// - an unmasked maskable request releases halt; a masked one keeps halt while macro service runs
// - reset releases halt regardless of mask, priority, enable, in-service
`timescale 1ns/1ps
`default_nettype none

`include "hsc_defs.svh"

module hsc_halt_ctrl (
  input  wire logic                       clk_sys_i,
  input  wire logic                       rst_b_i,
  // register port
  input  wire logic [`HSC_ADDR_W-1:0]     reg_addr_i,
  input  wire logic [7:0]                 reg_wdata_i,
  input  wire logic                       reg_wr_i,
  input  wire logic                       reg_rd_i,
  input  wire logic                       reg_wr_imm_i,
  output logic      [7:0]                 reg_rdata_o,
  // release sources
  input  wire logic                       nmi_req_i,
  input  wire logic                       maskable_req_i,
  input  wire logic                       macro_service_i,
  input  wire logic                       interrupt_mask_flag_i,
  input  wire logic                       interrupt_priority_flag_i,
  input  wire logic                       interrupt_enable_flag_i,
  input  wire logic                       in_service_priority_flag_i,
  // cpu side
  output logic                            cpu_clk_en_o,
  output logic                            cpu_halted_o,
  output logic                            macro_service_go_o,
  output logic                            vector_go_o,
  // bus from cpu
  input  wire logic [7:0]                 cpu_ad_o_i,
  input  wire logic                       cpu_ad_oe_b_i,
  input  wire logic [7:0]                 cpu_addr_mid_i,
  input  wire logic [3:0]                 cpu_addr_up_i,
  input  wire logic                       cpu_rd_b_i,
  input  wire logic                       cpu_wr_b_i,
  input  wire logic                       cpu_address_strobe_i,
  // bus pins
  output logic      [7:0]                 muxed_addr_data_low_o,
  output logic                            muxed_addr_data_low_oe_b_o,
  output logic      [7:0]                 addr_middle_lines_o,
  output logic      [3:0]                 addr_upper_lines_o,
  output logic                            rd_strobe_b_o,
  output logic                            wr_strobe_b_o,
  output logic                            address_strobe_o
);
  import hsc_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    hsc_state_t state;
    logic [7:0] standby_control_reg;
    hsc_src_t   last_src;
    logic       wake_pend;
    logic [7:0] rdata;
    logic       ad_oe_b;
    logic [7:0] ad;
  } hsc_ctrl_st_t;

  hsc_ctrl_st_t st_q;
  hsc_ctrl_st_t st_d;

  logic nmi_lvl;
  logic mask_lvl;
  logic mask_rel;
  logic any_rel;
  logic halt_wr;
  logic halted;
  logic [2:0] strb_pins;

  // ----------------------------------------------------------------
  // synchronised release requests
  // ----------------------------------------------------------------
  hsc_sync3 u_sync_nmi (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .async_i   (nmi_req_i),
    .level_o   (nmi_lvl)
  );

  hsc_sync3 u_sync_mask (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .async_i   (maskable_req_i),
    .level_o   (mask_lvl)
  );

  // ----------------------------------------------------------------
  // release decode
  // ----------------------------------------------------------------
  // unmasked request releases
  assign mask_rel = mask_lvl & ~interrupt_mask_flag_i;
  // nmi or maskable, reset handled below
  assign any_rel  = nmi_lvl | mask_rel;
  // only the immediate-move write to the standby control offset, any data value
  assign halt_wr  = reg_wr_i && reg_wr_imm_i && (reg_addr_i == `HSC_OFF_STBY_CTRL);

  // ----------------------------------------------------------------
  // controller
  // ----------------------------------------------------------------
  always_comb begin
    st_d       = st_q;
    st_d.rdata = 8'h00;
    // register write path
    if (halt_wr) begin
      st_d.standby_control_reg = reg_wdata_i;
    end
    case (st_q.state)
      HSC_RUN: begin
        if (halt_wr && reg_wdata_i[`HSC_HALT_BIT]) begin
          if (any_rel) begin
            st_d.standby_control_reg[`HSC_HALT_BIT] = 1'b0;
            st_d.last_src = nmi_lvl ? HSC_SRC_NMI : HSC_SRC_MASK;
          end else begin
            st_d.state = HSC_HALT;
            st_d.last_src = HSC_SRC_NONE;
          end
        end
      end
      HSC_HALT: begin
        if (nmi_lvl) begin
          st_d.state    = HSC_WAKE;
          st_d.last_src = HSC_SRC_NMI;
        end else if (mask_rel) begin
          st_d.state    = HSC_WAKE;
          st_d.last_src = HSC_SRC_MASK;
        end
      end
      HSC_WAKE: begin
        st_d.state = HSC_RUN;
        st_d.standby_control_reg[`HSC_HALT_BIT] = 1'b0;
      end
      default: begin
        st_d.state = HSC_RUN;
      end
    endcase
    st_d.wake_pend = (st_q.state == HSC_WAKE);
    st_d.ad_oe_b = (st_d.state == HSC_RUN) ? cpu_ad_oe_b_i : 1'b1;
    st_d.ad      = cpu_ad_o_i;
    // register read decode
    if (reg_rd_i) begin
      if (reg_addr_i == `HSC_OFF_STBY_CTRL) begin
        st_d.rdata = st_q.standby_control_reg;
      end else if (reg_addr_i == `HSC_OFF_STATUS) begin
        st_d.rdata = {4'h0, st_q.last_src, st_q.state};
      end else if (reg_addr_i == `HSC_OFF_FLAGS) begin
        st_d.rdata = {6'h00, in_service_priority_flag_i, interrupt_enable_flag_i};
      end else begin
        st_d.rdata = 8'h00;
      end
    end
  end

  // reset wins over every flag setting
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      st_q.state               <= HSC_RUN;
      st_q.standby_control_reg <= `HSC_STBY_RESET;
      st_q.last_src            <= HSC_SRC_NONE;
      st_q.wake_pend           <= 1'b0;
      st_q.rdata               <= 8'h00;
      st_q.ad_oe_b             <= 1'b1;
      st_q.ad                  <= 8'h00;
    end else begin
      st_q <= st_d;
    end
  end

  assign halted = (st_q.state == HSC_HALT);

  // ----------------------------------------------------------------
  // cpu side outputs
  // ----------------------------------------------------------------
  // cpu gated, macro service passes
  assign cpu_clk_en_o       = ~halted;
  assign cpu_halted_o       = halted;
  assign macro_service_go_o = macro_service_i & mask_lvl;
  // maskable vectored branch needs enable and priority above in-service level; nmi always vectors
  assign vector_go_o        = st_q.wake_pend & (st_q.last_src == HSC_SRC_NMI |
                              (interrupt_enable_flag_i &
                               (interrupt_priority_flag_i | ~in_service_priority_flag_i)));
  assign reg_rdata_o        = st_q.rdata;

  // ----------------------------------------------------------------
  // bus pin hold
  // ----------------------------------------------------------------
  // low lines float while not running; data follows the cpu
  assign muxed_addr_data_low_o      = st_q.ad;
  assign muxed_addr_data_low_oe_b_o = st_q.ad_oe_b;

  hsc_pin_hold #(.W(8)) u_hold_mid (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .halt_i    (halted),
    .freeze_i  (1'b1),
    .idle_i    (8'h00),
    .cpu_i     (cpu_addr_mid_i),
    .pin_o     (addr_middle_lines_o)
  );

  hsc_pin_hold #(.W(4)) u_hold_up (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .halt_i    (halted),
    .freeze_i  (1'b0),
    .idle_i    (`HSC_UPPER_IDLE),
    .cpu_i     (cpu_addr_up_i),
    .pin_o     (addr_upper_lines_o)
  );

  hsc_pin_hold #(.W(3)) u_hold_strb (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .halt_i    (halted),
    .freeze_i  (1'b0),
    .idle_i    ({`HSC_STRB_IDLE, `HSC_STRB_IDLE, `HSC_ADDRESS_STROBE_IDLE}),
    .cpu_i     ({cpu_rd_b_i, cpu_wr_b_i, cpu_address_strobe_i}),
    .pin_o     (strb_pins)
  );

  assign rd_strobe_b_o    = strb_pins[2];
  assign wr_strobe_b_o    = strb_pins[1];
  assign address_strobe_o = strb_pins[0];

endmodule

`default_nettype wire

// ===== inc/hsc_defs.svh
// halt standby control: offsets, field positions, reset values, timing counts
// assumes inclusion by bare name from design and bench files
`ifndef HSC_DEFS_SVH
`define HSC_DEFS_SVH

// register offsets on the plain register port
`define HSC_ADDR_W          4
`define HSC_OFF_STBY_CTRL   4'h0
`define HSC_OFF_STATUS      4'h1
`define HSC_OFF_FLAGS       4'h2

// standby control register fields
`define HSC_HALT_BIT        0
`define HSC_STBY_RESET      8'h00
`define HSC_HALT_CODE       8'h01

// flags register field positions
`define HSC_FLG_IE_BIT      0
`define HSC_FLG_ISP_BIT     1

// pin idle values during halt
`define HSC_UPPER_IDLE      4'h0
`define HSC_STRB_IDLE       1'b1
`define HSC_ADDRESS_STROBE_IDLE       1'b0

// release restart: cycles the cpu clock gate needs to reopen
`define HSC_WAKE_NS         25
`define HSC_CLK_NS          25
`define HSC_WAKE_CYC        ((`HSC_WAKE_NS + `HSC_CLK_NS - 1) / `HSC_CLK_NS)

`endif

// ===== inc/hsc_pkg.sv
// halt standby control: shared types
// assumes hsc_defs.svh sits on the include path
package hsc_pkg;

  // controller states
  typedef enum logic [1:0] {
    HSC_RUN  = 2'b00,
    HSC_HALT = 2'b01,
    HSC_WAKE = 2'b10
  } hsc_state_t;

  // release cause reported to software
  typedef enum logic [1:0] {
    HSC_SRC_NONE = 2'b00,
    HSC_SRC_NMI  = 2'b01,
    HSC_SRC_MASK = 2'b10
  } hsc_src_t;

endpackage

// ===== hdl/hsc_sync3.sv
// three-stage synchroniser for one asynchronous level
// assumes clk_sys_i is the only clock; change counts when stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module hsc_sync3 (
  input  wire logic clk_sys_i,
  input  wire logic rst_b_i,
  input  wire logic async_i,
  output logic      level_o
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } hsc_sync_st_t;

  hsc_sync_st_t st_q;
  hsc_sync_st_t st_d;

  // shift chain, level accepted once s2 and s3 agree
  always_comb begin
    st_d     = st_q;
    st_d.s1  = async_i;
    st_d.s2  = st_q.s1;
    st_d.s3  = st_q.s2;
    if (st_q.s2 == st_q.s3) begin
      st_d.lvl = st_q.s3;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign level_o = st_q.lvl;

endmodule

`default_nettype wire

// ===== hdl/hsc_pin_hold.sv
// holds one group of bus pin outputs at a fixed or frozen level while halted
// assumes halt_i is a registered level from the controller
`timescale 1ns/1ps
`default_nettype none

module hsc_pin_hold #(
  parameter int W = 8
) (
  input  wire logic         clk_sys_i,
  input  wire logic         rst_b_i,
  input  wire logic         halt_i,
  input  wire logic         freeze_i,
  input  wire logic [W-1:0] idle_i,
  input  wire logic [W-1:0] cpu_i,
  output logic      [W-1:0] pin_o
);

  typedef struct packed {
    logic [W-1:0] pin;
  } hsc_hold_st_t;

  hsc_hold_st_t st_q;
  hsc_hold_st_t st_d;

  // running: follow cpu; halted: keep last value or force idle
  always_comb begin
    st_d = st_q;
    if (!halt_i) begin
      st_d.pin = cpu_i;
    end else if (!freeze_i) begin
      st_d.pin = idle_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign pin_o = st_q.pin;

endmodule

`default_nettype wire

// ===== sim/hsc_irq_src.sv
// interrupt source model: request levels that stand until serviced
// assumes vector_go_o of the controller acknowledges a pending request
`timescale 1ns/1ps
`default_nettype none

module hsc_irq_src (
  input  wire logic clk_sys_i,
  input  wire logic rst_b_i,
  input  wire logic nmi_set_i,
  input  wire logic msk_set_i,
  input  wire logic ack_i,
  input  wire logic clr_i,
  output logic      nmi_req_o,
  output logic      maskable_req_o
);
  // requests latch on set and drop on acknowledge, clear or reset
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i || ack_i || clr_i) begin
      nmi_req_o      <= 1'b0;
      maskable_req_o <= 1'b0;
    end else begin
      nmi_req_o      <= nmi_req_o | nmi_set_i;
      maskable_req_o <= maskable_req_o | msk_set_i;
    end
  end
endmodule

`default_nettype wire

// ===== sim/hsc_chk_assertions.sv
// timing checks on the halt controller ports
// assumes one clock domain and binding onto hsc_halt_ctrl
`timescale 1ns/1ps
`default_nettype none

`include "hsc_defs.svh"

module hsc_chk (
  input wire logic                   clk_sys_i,
  input wire logic                   rst_b_i,
  input wire logic [`HSC_ADDR_W-1:0] reg_addr_i,
  input wire logic [7:0]             reg_wdata_i,
  input wire logic                   reg_wr_i,
  input wire logic                   reg_rd_i,
  input wire logic                   reg_wr_imm_i,
  input wire logic [7:0]             reg_rdata_o,
  input wire logic                   nmi_req_i,
  input wire logic                   maskable_req_i,
  input wire logic                   interrupt_mask_flag_i,
  input wire logic                   cpu_clk_en_o,
  input wire logic                   cpu_halted_o,
  input wire logic                   vector_go_o,
  input wire logic                   muxed_addr_data_low_oe_b_o,
  input wire logic [7:0]             addr_middle_lines_o,
  input wire logic [3:0]             addr_upper_lines_o,
  input wire logic                   rd_strobe_b_o,
  input wire logic                   wr_strobe_b_o,
  input wire logic                   address_strobe_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);

  // steps of a halt entry and of a settled halt
  // five quiet cycles: the three-flop synchroniser shows a raw level four edges late
  sequence quiet_s; (!nmi_req_i && !maskable_req_i) [*5]; endsequence
  sequence halt_wr_s; reg_wr_i && reg_wr_imm_i && reg_addr_i == 4'h0 && reg_wdata_i == 8'h01;
  endsequence
  sequence halted2_s; cpu_halted_o [*2]; endsequence

  halt_entry_a: assert property (quiet_s ##0 halt_wr_s |=> cpu_halted_o)
    else $error("halt write did not halt");
  plain_wr_a: assert property (reg_wr_i && !reg_wr_imm_i && !cpu_halted_o |=> !cpu_halted_o)
    else $error("plain write halted");
  clk_gate_a: assert property (cpu_clk_en_o == !cpu_halted_o)
    else $error("cpu clock enable wrong");
  halt_float_a: assert property (halted2_s |-> muxed_addr_data_low_oe_b_o && addr_upper_lines_o == 4'h0)
    else $error("low or upper lines not idle");
  halt_strb_a: assert property (halted2_s |-> rd_strobe_b_o && wr_strobe_b_o && !address_strobe_o)
    else $error("strobes not idle");
  mid_hold_a: assert property (halted2_s |-> $stable(addr_middle_lines_o))
    else $error("middle lines moved");
  nmi_wake_a: assert property (cpu_halted_o && nmi_req_i |-> ##[1:6] !cpu_halted_o)
    else $error("nmi did not release");
  mask_wake_a: assert property (cpu_halted_o && maskable_req_i && !interrupt_mask_flag_i
    |-> ##[1:6] !cpu_halted_o)
    else $error("maskable request did not release");
  wake_vec_a: assert property ($fell(cpu_halted_o) && nmi_req_i |=> vector_go_o)
    else $error("no vector after wake");
  vec_once_a: assert property (vector_go_o |=> !vector_go_o && !cpu_halted_o)
    else $error("vector pulse too long");
  rd_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("read data outside read slot");
endmodule

bind hsc_halt_ctrl hsc_chk u_chk (.*);

`default_nettype wire

// ===== sim/tb_top.sv
// bench for the halt controller: register port tasks and release scenarios
// assumes hsc_pkg compiled first and hsc_defs.svh on the include path
`timescale 1ns/1ps
`default_nettype none

`include "hsc_defs.svh"

module tb_top;
  import hsc_pkg::*;
  logic [`HSC_ADDR_W-1:0] reg_addr_i;
  logic       clk_sys_i, rst_b_i, reg_wr_i, reg_rd_i, reg_wr_imm_i, nmi_req_i, maskable_req_i;
  logic [3:0] cpu_addr_up_i, addr_upper_lines_o;
  logic [7:0] reg_wdata_i, reg_rdata_o, cpu_ad_o_i, cpu_addr_mid_i;
  logic [7:0] muxed_addr_data_low_o, addr_middle_lines_o;
  logic       macro_service_i, interrupt_mask_flag_i, interrupt_priority_flag_i;
  logic       interrupt_enable_flag_i, in_service_priority_flag_i;
  logic       cpu_clk_en_o, cpu_halted_o, macro_service_go_o, vector_go_o;
  logic       cpu_ad_oe_b_i, cpu_rd_b_i, cpu_wr_b_i, cpu_address_strobe_i;
  logic       muxed_addr_data_low_oe_b_o, rd_strobe_b_o, wr_strobe_b_o, address_strobe_o;
  logic       nmi_set, msk_set, src_clr;
  int         err_total, n_compared, i;

  hsc_halt_ctrl u_dut (.*);
  hsc_irq_src u_src (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .nmi_set_i(nmi_set),
    .msk_set_i(msk_set), .ack_i(vector_go_o), .clr_i(src_clr), .nmi_req_o(nmi_req_i),
    .maskable_req_o(maskable_req_i));

  // 40 MHz system clock
  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic imm);
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b1;
    reg_wr_imm_i <= imm;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
    reg_wr_imm_i <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string nm);
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(nm, exp, reg_rdata_o);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  // bounded wait for the halted flag to drop
  task automatic wait_run;
    i = 0;
    while (i < 12 && cpu_halted_o !== 1'b0) begin
      @(posedge clk_sys_i);
      #1;
      i++;
    end
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // watchdog at 3000 cycles, well beyond the hundred or so cycles the tests need
  initial begin
    #(25 * 3000);
    err_total++;
    close_out();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {reg_wr_i, reg_rd_i, reg_wr_imm_i, reg_addr_i, reg_wdata_i, rst_b_i} = '0;
    {macro_service_i, interrupt_mask_flag_i, interrupt_priority_flag_i} = '0;
    {interrupt_enable_flag_i, in_service_priority_flag_i, nmi_set, msk_set, src_clr} = '0;
    {cpu_ad_o_i, cpu_ad_oe_b_i, cpu_addr_mid_i, cpu_addr_up_i} = {8'h3c, 1'b0, 8'h5a, 4'hf};
    {cpu_rd_b_i, cpu_wr_b_i, cpu_address_strobe_i} = 3'b001;
    {err_total, n_compared} = '0;
    repeat (2) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    rd(`HSC_OFF_STATUS, 8'h00, "status");
    rd(`HSC_OFF_STBY_CTRL, `HSC_STBY_RESET, "stby");
    rd(4'h7, 8'h00, "unmapped");
    wr(`HSC_OFF_STBY_CTRL, `HSC_HALT_CODE, 1'b0);
    chk("halted", 8'h00, cpu_halted_o);
    wr(`HSC_OFF_STATUS, `HSC_HALT_CODE, 1'b1);
    chk("halted", 8'h00, cpu_halted_o);
    $display("test reset and refusal done");
    wr(`HSC_OFF_STBY_CTRL, `HSC_HALT_CODE, 1'b1);
    chk("halted", 8'h01, cpu_halted_o);
    chk("clk_en", 8'h00, cpu_clk_en_o);
    cyc(1);
    chk("oe_b", 8'h01, muxed_addr_data_low_oe_b_o);
    chk("upper", `HSC_UPPER_IDLE, addr_upper_lines_o);
    chk("strobes", 8'h03, {rd_strobe_b_o, wr_strobe_b_o});
    chk("address_strobe", `HSC_ADDRESS_STROBE_IDLE, address_strobe_o);
    chk("ad_low", 8'h3c, muxed_addr_data_low_o);
    // macro service runs while a masked request keeps halt
    cpu_addr_mid_i = 8'ha5;
    {interrupt_mask_flag_i, macro_service_i, msk_set} = 3'b111;
    cyc(1);
    msk_set = 1'b0;
    cyc(6);
    chk("macro_go", 8'h01, macro_service_go_o);
    chk("halted", 8'h01, cpu_halted_o);
    chk("middle", 8'h5a, addr_middle_lines_o);
    rd(`HSC_OFF_STATUS, 8'h01, "status");
    src_clr = 1'b1;
    cyc(1);
    src_clr = 1'b0;
    cyc(6);
    {interrupt_mask_flag_i, macro_service_i} = 2'b00;
    $display("test halt entry done");
    nmi_set = 1'b1;
    cyc(1);
    nmi_set = 1'b0;
    wait_run();
    chk("halted", 8'h00, cpu_halted_o);
    chk("clk_en", 8'h01, cpu_clk_en_o);
    cyc(1);
    chk("vector", 8'h01, vector_go_o);
    rd(`HSC_OFF_STATUS, 8'h04, "status");
    rd(`HSC_OFF_STBY_CTRL, 8'h00, "stby");
    cyc(6);
    $display("test nmi release done");
    {interrupt_enable_flag_i, interrupt_priority_flag_i} = 2'b11;
    wr(`HSC_OFF_STBY_CTRL, `HSC_HALT_CODE, 1'b1);
    chk("halted", 8'h01, cpu_halted_o);
    msk_set = 1'b1;
    cyc(1);
    msk_set = 1'b0;
    wait_run();
    chk("halted", 8'h00, cpu_halted_o);
    cyc(1);
    chk("vector", 8'h01, vector_go_o);
    rd(`HSC_OFF_STATUS, 8'h08, "status");
    cyc(6);
    $display("test maskable release done");
    // halt request while a release is pending
    interrupt_enable_flag_i = 1'b0;
    msk_set = 1'b1;
    cyc(1);
    msk_set = 1'b0;
    cyc(6);
    wr(`HSC_OFF_STBY_CTRL, `HSC_HALT_CODE, 1'b1);
    chk("halted", 8'h00, cpu_halted_o);
    rd(`HSC_OFF_STBY_CTRL, 8'h00, "stby");
    src_clr = 1'b1;
    cyc(1);
    src_clr = 1'b0;
    cyc(6);
    $display("test pending request done");
    // reset releases whatever the flags say
    {interrupt_mask_flag_i, interrupt_priority_flag_i} = 2'b11;
    {interrupt_enable_flag_i, in_service_priority_flag_i} = 2'b11;
    wr(`HSC_OFF_STBY_CTRL, `HSC_HALT_CODE, 1'b1);
    chk("halted", 8'h01, cpu_halted_o);
    @(posedge clk_sys_i);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    #1;
    chk("halted", 8'h00, cpu_halted_o);
    chk("clk_en", 8'h01, cpu_clk_en_o);
    rd(`HSC_OFF_STBY_CTRL, `HSC_STBY_RESET, "stby");
    $display("test reset release done");
    close_out();
  end
endmodule

`default_nettype wire
